// File: core/sync_terminal_router.sv
/*
 * Sync terminal router: APB-programmed routing of internal timing terminals
 * onto the shared sync lines, master timebase selection, resync and start
 * trigger handling. Assumes the sync line, star, clock and fault pins are asynchronous to core_clk_i and
 * that the CAN controller signals arrive on core_clk_i.
 */
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "sync_router_cfg.svh"

module sync_terminal_router
    import sync_router_pkg::*;
#(
    parameter int RESYNC_HALF_CYC = `RESYNC_HALF_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [6:0] general_sync_lines_i,
    output logic [6:0] general_sync_lines_o,
    output logic [6:0] general_sync_lines_oe_o,
    input wire logic timebase_sync_line_i,
    output logic timebase_sync_line_o,
    output logic timebase_sync_line_oe_o,
    input wire logic star_trigger_i,
    input wire logic backplane_clk10_i,
    input wire logic local_osc_i,
    input wire logic [1:0] transceiver_fault_n_i,
    input wire logic [1:0] rx_eof_last_bit_i,
    input wire logic [1:0] rx_accepted_i,
    input wire logic [1:0] comm_begin_i,
    output logic [1:0] start_trigger_o,
    output logic [1:0] rx_event_o,
    output logic sample_tick_o,
    output logic [31:0] timestamp_o
);

    function automatic logic line_ok(input logic [3:0] idx, input variant_t v);
        logic ok;
        case (v)
            VAR_USB: ok = (idx == 4'h0);
            VAR_PCCARD: ok = (idx < 4'h4);
            default: ok = (idx < 4'h7);
        endcase
        return ok;
    endfunction

    function automatic logic valid_pair(input logic [3:0] s, input logic [3:0] d,
                                        input logic p, input variant_t v,
                                        input logic [4:0] slot);
        logic dl;
        logic ok;
        dl = line_ok(d, v);
        case (s)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
                ok = line_ok(s, v) && (d == DST_START ||
                     (d == DST_RESYNC && v != VAR_USB));
            end
            SRC_TB_LINE: ok = (d == DST_MASTER);
            SRC_STAR: begin
                ok = d == DST_START && v == VAR_PXI && slot >= `STAR_MIN_SLOT;
            end
            SRC_CLK10: ok = (d == DST_MASTER) && (v == VAR_PXI);
            SRC_LOCAL: ok = (d == DST_TB_LINE) && (v != VAR_PCCARD);
            SRC_RESYNC: ok = v != VAR_USB && (dl || d == DST_START);
            SRC_RX_EVENT: ok = v != VAR_USB && (dl || d == DST_START);
            SRC_FAULT: ok = v != VAR_USB && dl && (d[0] == p);
            SRC_START: ok = dl;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return a == `REG_CTRL || a == `REG_CONNECT || a == `REG_STATUS ||
               a == `REG_START_ARM || a == `REG_TIMESTAMP || a == `REG_LINE_MAP;
    endfunction

    // pin synchronisers: gen[6:0], tb[7], star[8], clk10[9], osc[10], fault_n[12:11]
    logic [12:0] pin_raw;
    logic [12:0] meta_reg;
    logic [12:0] sync_reg;
    logic [12:0] prev_reg;
    logic [12:0] rise;

    assign pin_raw = {transceiver_fault_n_i, local_osc_i, backplane_clk10_i,
                      star_trigger_i, timebase_sync_line_i, general_sync_lines_i};

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= 13'h1800;
            sync_reg <= 13'h1800;
            prev_reg <= 13'h1800;
        end else begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~prev_reg;

    // control registers
    logic rate10_reg;
    variant_t variant_reg;
    logic [4:0] slot_reg;
    logic [31:0] last_cmd_reg;
    logic err_reg;

    logic [3:0] line_src_reg [7];
    logic [6:0] line_port_reg;
    logic [6:0] line_en_reg;
    logic tb_export_reg;
    tb_sel_t master_sel_reg;
    logic resync_en_reg;
    logic [2:0] resync_line_reg;
    logic [1:0] start_en_reg;
    logic [3:0] start_src_reg [2];

    logic setup;
    logic wr;
    logic [3:0] c_src;
    logic [3:0] c_dst;
    logic c_port;
    logic c_conn;
    logic c_ok;

    assign setup = psel_i && !penable_i;
    assign wr = psel_i && penable_i && pwrite_i && mapped(paddr_i);
    assign c_src = pwdata_i[`CMD_SRC_LSB +: 4];
    assign c_dst = pwdata_i[`CMD_DST_LSB +: 4];
    assign c_port = pwdata_i[`CMD_PORT_BIT];
    assign c_conn = pwdata_i[`CMD_CONNECT_BIT];
    // a disconnect only needs a known destination
    assign c_ok = c_conn ? valid_pair(c_src, c_dst, c_port, variant_reg, slot_reg)
                         : (c_dst <= DST_START);

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rate10_reg <= 1'b0;
            variant_reg <= VAR_PCI;
            slot_reg <= 5'h03;
        end else if (wr && paddr_i == `REG_CTRL) begin
            rate10_reg <= pwdata_i[`CTRL_RATE10_BIT];
            variant_reg <= variant_t'(pwdata_i[`CTRL_VARIANT_LSB +: 2]);
            slot_reg <= pwdata_i[`CTRL_SLOT_LSB +: 5];
        end
    end

    // one route table for the whole card, shared by both ports
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_cmd_reg <= 32'h0;
            err_reg <= 1'b0;
            line_port_reg <= 7'h0;
            line_en_reg <= 7'h0;
            tb_export_reg <= 1'b0;
            master_sel_reg <= TB_LOCAL;
            resync_en_reg <= 1'b0;
            resync_line_reg <= 3'h0;
            start_en_reg <= 2'h0;
            for (int i = 0; i < `GEN_LINES; i++) begin
                line_src_reg[i] <= 4'h0;
            end
            start_src_reg[0] <= 4'h0;
            start_src_reg[1] <= 4'h0;
        end else if (wr && paddr_i == `REG_CONNECT) begin
            last_cmd_reg <= pwdata_i;
            err_reg <= !c_ok;
            if (c_ok) begin
                case (c_dst)
                    DST_TB_LINE: tb_export_reg <= c_conn;
                    DST_MASTER: begin
                        if (!c_conn) begin
                            master_sel_reg <= TB_LOCAL;
                        end else if (c_src == SRC_CLK10) begin
                            master_sel_reg <= TB_CLK10;
                        end else begin
                            master_sel_reg <= TB_LINE7;
                        end
                    end
                    DST_RESYNC: begin
                        resync_en_reg <= c_conn;
                        resync_line_reg <= c_src[2:0];
                    end
                    DST_START: begin
                        start_en_reg[c_port] <= c_conn;
                        start_src_reg[c_port] <= c_src;
                    end
                    default: begin
                        line_en_reg[c_dst[2:0]] <= c_conn;
                        line_src_reg[c_dst[2:0]] <= c_src;
                        line_port_reg[c_dst[2:0]] <= c_port;
                    end
                endcase
            end
        end
    end

    // rate sensing on the timebase line, used by the usb variant
    logic [7:0] per_cnt_reg;
    rate_t det_rate_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            per_cnt_reg <= 8'h0;
            det_rate_reg <= RATE_20M;
        end else if (rise[7]) begin
            per_cnt_reg <= 8'h1;
            if (per_cnt_reg <= `RATE20_MAX_CYC) begin
                det_rate_reg <= RATE_20M;
            end else if (per_cnt_reg <= `RATE10_MAX_CYC) begin
                det_rate_reg <= RATE_10M;
            end else begin
                det_rate_reg <= RATE_1M;
            end
        end else if (per_cnt_reg != 8'hff) begin
            per_cnt_reg <= per_cnt_reg + 8'h1;
        end
    end

    // master timebase: edges of the selected source, divided to 1 us ticks.
    // limitation: a 20 MHz source is undersampled by the 50 MHz core clock,
    // so the tick rate only tracks it on average
    logic tb_edge;
    logic [4:0] tb_div;
    logic resync_edge;
    logic [4:0] pre_cnt_reg;
    logic [31:0] ts_reg;
    logic sample_reg;

    always_comb begin
        tb_edge = rise[10];
        tb_div = (variant_reg == VAR_USB) ? `DIV_1M : `DIV_20M;
        case (master_sel_reg)
            TB_LINE7: begin
                tb_edge = rise[7];
                if (variant_reg == VAR_USB) begin
                    tb_div = (det_rate_reg == RATE_1M) ? `DIV_1M :
                             (det_rate_reg == RATE_10M) ? `DIV_10M : `DIV_20M;
                end else if (variant_reg == VAR_PCCARD || rate10_reg) begin
                    tb_div = `DIV_10M;
                end else begin
                    tb_div = `DIV_20M;
                end
            end
            TB_CLK10: begin
                tb_edge = rise[9];
                tb_div = `DIV_10M;
            end
            default: begin
                tb_edge = rise[10];
            end
        endcase
    end

    assign resync_edge = resync_en_reg && rise[resync_line_reg];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt_reg <= 5'h0;
            ts_reg <= 32'h0;
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= 1'b0;
            if (resync_edge) begin
                pre_cnt_reg <= 5'h0;
            end else if (tb_edge) begin
                if (pre_cnt_reg >= tb_div - 5'h1) begin
                    pre_cnt_reg <= 5'h0;
                    ts_reg <= ts_reg + 32'h1;
                    sample_reg <= 1'b1;
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 5'h1;
                end
            end
        end
    end

    // 10 hz resync square wave and the 1 mhz usb export clock
    logic [22:0] rs_cnt_reg;
    logic resync_clk_reg;
    logic [4:0] usb_cnt_reg;
    logic usb_clk_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rs_cnt_reg <= 23'h0;
            resync_clk_reg <= 1'b0;
        end else if (rs_cnt_reg == 23'(RESYNC_HALF_CYC - 1)) begin
            rs_cnt_reg <= 23'h0;
            resync_clk_reg <= !resync_clk_reg;
        end else begin
            rs_cnt_reg <= rs_cnt_reg + 23'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            usb_cnt_reg <= 5'h0;
            usb_clk_reg <= 1'b0;
        end else if (usb_cnt_reg == 5'(`USB_HALF_CYC - 1)) begin
            usb_cnt_reg <= 5'h0;
            usb_clk_reg <= !usb_clk_reg;
        end else begin
            usb_cnt_reg <= usb_cnt_reg + 5'h1;
        end
    end

    // receive event: the controller marks the last eof bit for a full bit time
    logic [1:0] rx_ev_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_ev_reg <= 2'h0;
        end else begin
            rx_ev_reg <= rx_eof_last_bit_i & rx_accepted_i;
        end
    end

    // start trigger per interface; started blocks retriggering until rearmed
    logic [1:0] started_reg;
    logic [1:0] start_fire;
    logic [1:0] start_arm;
    logic [1:0] start_pulse_reg;

    assign start_arm = (wr && paddr_i == `REG_START_ARM) ? pwdata_i[1:0] : 2'h0;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (start_en_reg[p]) begin
                start_fire[p] = !started_reg[p] && (start_src_reg[p] == SRC_STAR ?
                    rise[8] : rise[start_src_reg[p][2:0]]);
            end else begin
                start_fire[p] = !started_reg[p] && comm_begin_i[p];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            started_reg <= 2'h0;
            start_pulse_reg <= 2'h0;
        end else begin
            // a trigger landing on the rearm cycle is lost, since started still blocks it
            started_reg <= start_fire | (started_reg & ~start_arm);
            start_pulse_reg <= start_fire;
        end
    end

    // line drivers
    logic [6:0] line_val;

    always_comb begin
        for (int i = 0; i < `GEN_LINES; i++) begin
            case (line_src_reg[i])
                SRC_RESYNC: line_val[i] = resync_clk_reg;
                SRC_RX_EVENT: line_val[i] = rx_ev_reg[line_port_reg[i]];
                SRC_FAULT: line_val[i] = sync_reg[11 + line_port_reg[i]];
                SRC_START: line_val[i] = start_pulse_reg[line_port_reg[i]];
                default: line_val[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            general_sync_lines_o <= 7'h0;
            general_sync_lines_oe_o <= 7'h0;
            timebase_sync_line_o <= 1'b0;
            timebase_sync_line_oe_o <= 1'b0;
        end else begin
            general_sync_lines_o <= line_val & line_en_reg;
            general_sync_lines_oe_o <= line_en_reg;
            // only the local clock is ever exported, never an imported one
            timebase_sync_line_o <= tb_export_reg &&
                (variant_reg == VAR_USB ? usb_clk_reg : sync_reg[10]);
            timebase_sync_line_oe_o <= tb_export_reg;
        end
    end

    assign start_trigger_o = start_pulse_reg;
    assign rx_event_o = rx_ev_reg;
    assign sample_tick_o = sample_reg;
    assign timestamp_o = ts_reg;

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0;
        end else if (setup && !pwrite_i) begin
            case (paddr_i)
                `REG_CTRL: prdata_o <= {24'h0, slot_reg, variant_reg, rate10_reg};
                `REG_CONNECT: prdata_o <= last_cmd_reg;
                `REG_STATUS: prdata_o <= {23'h0, tb_export_reg, resync_en_reg,
                                          master_sel_reg, det_rate_reg,
                                          started_reg, err_reg};
                `REG_TIMESTAMP: prdata_o <= ts_reg;
                `REG_LINE_MAP: prdata_o <= {25'h0, line_en_reg};
                default: prdata_o <= 32'h0;
            endcase
        end
    end

endmodule // sync_terminal_router

// File: core/sync_router_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * sync terminal router. Assumes a 50 MHz core clock and a 32-bit APB.
 */
`ifndef SYNC_ROUTER_CFG_SVH
`define SYNC_ROUTER_CFG_SVH

`define CORE_CLK_HZ 50000000
`define RESYNC_HZ 10
`define RESYNC_HALF_CYC (`CORE_CLK_HZ / (2 * `RESYNC_HZ))
`define USB_EXPORT_HZ 1000000
`define USB_HALF_CYC (`CORE_CLK_HZ / (2 * `USB_EXPORT_HZ))

`define REG_CTRL 12'h000
`define REG_CONNECT 12'h004
`define REG_STATUS 12'h008
`define REG_START_ARM 12'h00c
`define REG_TIMESTAMP 12'h010
`define REG_LINE_MAP 12'h014

`define CTRL_RATE10_BIT 0
`define CTRL_VARIANT_LSB 1
`define CTRL_SLOT_LSB 3
`define CTRL_RESET 32'h0000_0018

`define CMD_SRC_LSB 0
`define CMD_DST_LSB 4
`define CMD_PORT_BIT 8
`define CMD_CONNECT_BIT 9

`define STAR_MIN_SLOT 5'h03
`define DIV_20M 5'h14
`define DIV_10M 5'h0a
`define DIV_1M 5'h01
`define RATE20_MAX_CYC 8'h03
`define RATE10_MAX_CYC 8'h07
`define GEN_LINES 7

`endif

// File: core/sync_router_pkg.sv
/*
 * Types of the sync terminal router: terminal codes, variants and
 * timebase selections. Constants live in sync_router_cfg.svh.
 */
package sync_router_pkg;

    typedef enum logic [3:0] {
        SRC_LINE0 = 4'h0,
        SRC_LINE6 = 4'h6,
        SRC_TB_LINE = 4'h7,
        SRC_STAR = 4'h8,
        SRC_CLK10 = 4'h9,
        SRC_LOCAL = 4'ha,
        SRC_RESYNC = 4'hb,
        SRC_RX_EVENT = 4'hc,
        SRC_FAULT = 4'hd,
        SRC_START = 4'he
    } src_t;

    typedef enum logic [3:0] {
        DST_LINE0 = 4'h0,
        DST_LINE6 = 4'h6,
        DST_TB_LINE = 4'h7,
        DST_MASTER = 4'h8,
        DST_RESYNC = 4'h9,
        DST_START = 4'ha
    } dst_t;

    typedef enum logic [1:0] {
        VAR_PCI = 2'h0,
        VAR_PXI = 2'h1,
        VAR_PCCARD = 2'h2,
        VAR_USB = 2'h3
    } variant_t;

    typedef enum logic [1:0] {
        TB_LOCAL = 2'h0,
        TB_LINE7 = 2'h1,
        TB_CLK10 = 2'h3
    } tb_sel_t;

    typedef enum logic [1:0] {
        RATE_20M = 2'h0,
        RATE_10M = 2'h1,
        RATE_1M = 2'h3
    } rate_t;

endpackage

// File: test/sync_router_properties.sv
/*
 * Port checker for the sync terminal router.
 * Assumes one core clock domain and reset low while rst_b_i is low.
 */
`timescale 1ns/1ps
module sync_router_properties #(
    parameter int RESYNC_HALF_CYC = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [6:0] general_sync_lines_oe_o,
    input wire logic timebase_sync_line_oe_o,
    input wire logic [1:0] rx_eof_last_bit_i,
    input wire logic [1:0] rx_accepted_i,
    input wire logic [1:0] start_trigger_o,
    input wire logic [1:0] rx_event_o,
    input wire logic sample_tick_o,
    input wire logic [31:0] timestamp_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i && prdata_o == 32'h0)
        else $error("error outside access or with data");
    a_rx_event_follow: assert property (rx_event_o == $past(rx_eof_last_bit_i & rx_accepted_i))
        else $error("receive event does not follow frame end");
    a_start0_single: assert property (start_trigger_o[0] |=> !start_trigger_o[0])
        else $error("start pulse port 0 too long");
    a_start1_single: assert property (start_trigger_o[1] |=> !start_trigger_o[1])
        else $error("start pulse port 1 too long");
    a_tick_single: assert property (sample_tick_o |=> !sample_tick_o)
        else $error("sample tick too long");
    a_stamp_step: assert property ($changed(timestamp_o) |-> timestamp_o == $past(timestamp_o) + 32'h1)
        else $error("timestamp jumped");
    a_line_oe_cause: assert property ($changed(general_sync_lines_oe_o)
        |-> $past(psel_i && penable_i && pwrite_i) || $past(psel_i && penable_i && pwrite_i, 2))
        else $error("line drive changed without a write");
    a_tb_oe_cause: assert property ($changed(timebase_sync_line_oe_o)
        |-> $past(psel_i && penable_i && pwrite_i) || $past(psel_i && penable_i && pwrite_i, 2))
        else $error("timebase drive changed without a write");
endmodule // sync_router_properties

bind sync_terminal_router sync_router_properties #(.RESYNC_HALF_CYC(RESYNC_HALF_CYC))
    sync_router_properties_i (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
    .prdata_o, .pready_o, .pslverr_o, .general_sync_lines_oe_o, .timebase_sync_line_oe_o,
    .rx_eof_last_bit_i, .rx_accepted_i, .start_trigger_o, .rx_event_o, .sample_tick_o,
    .timestamp_o);

// File: test/sync_far_cards.sv
/*
 * Other cards on the shared sync lines: drive lines and a timebase clock.
 * Assumes the bench sets which lines the far side drives.
 */
`timescale 1ns/1ps
module sync_far_cards (
    input wire logic core_clk_i,
    input wire logic clk_run_i,
    input wire logic [6:0] far_oe_i,
    input wire logic [6:0] far_val_i,
    input wire logic [6:0] dut_lines_i,
    input wire logic [6:0] dut_oe_i,
    input wire logic dut_tb_i,
    input wire logic dut_tb_oe_i,
    output logic [6:0] lines_o,
    output logic tb_line_o
);
    logic tb_clk = 1'b0;
    logic [6:0] last = 7'h00;
    logic tb_last = 1'b0;
    // clock stands still outside frames
    always begin
        #80;
        tb_clk = clk_run_i ? ~tb_clk : 1'b0;
    end
    // released lines show a changing pattern, not the old level
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            lines_o[k] = dut_oe_i[k] ? dut_lines_i[k] : far_oe_i[k] ? far_val_i[k] : ~last[k];
        end
        tb_line_o = dut_tb_oe_i ? dut_tb_i : clk_run_i ? tb_clk : ~tb_last;
    end
    always @(posedge core_clk_i) begin
        last <= lines_o;
        tb_last <= tb_line_o;
    end
endmodule // sync_far_cards

// File: test/sync_terminal_router_tb.sv
/*
 * Bench for the sync terminal router: APB tasks and routing tests.
 * Assumes the far cards model resolves the shared lines.
 */
`timescale 1ns/1ps
`include "sync_router_cfg.svh"
module sync_terminal_router_tb;
    import sync_router_pkg::*;
    localparam int HALF = 10;
    logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, stamp;
    logic pready, pslverr, e, tick, tb_in, tb_out, tb_oe, clk_run = 1'b0;
    logic [6:0] lines_in, lines_out, lines_oe, far_oe = 7'h7f, far_val = 7'h00;
    logic [1:0] cnt = 2'h0, fault_n = 2'h3, eof = 2'h0, acc = 2'h0, begin_c = 2'h0;
    logic [1:0] start, rx_event;
    int n_fail = 0, compares = 0, hi_cnt, tg_cnt;
    int st_cnt [2] = '{0, 0};
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cnt <= cnt + 2'h1;
        for (int p = 0; p < 2; p++) st_cnt[p] += (start[p] === 1'b1);
    end
    sync_terminal_router #(.RESYNC_HALF_CYC(HALF)) sync_terminal_router_i (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .general_sync_lines_i(lines_in),
        .general_sync_lines_o(lines_out), .general_sync_lines_oe_o(lines_oe),
        .timebase_sync_line_i(tb_in), .timebase_sync_line_o(tb_out),
        .timebase_sync_line_oe_o(tb_oe), .star_trigger_i(1'b0), .backplane_clk10_i(cnt[1]),
        .local_osc_i(cnt[0]), .transceiver_fault_n_i(fault_n), .rx_eof_last_bit_i(eof),
        .rx_accepted_i(acc), .comm_begin_i(begin_c), .start_trigger_o(start),
        .rx_event_o(rx_event), .sample_tick_o(tick), .timestamp_o(stamp));
    sync_far_cards sync_far_cards_i (.core_clk_i(core_clk), .clk_run_i(clk_run),
        .far_oe_i(far_oe), .far_val_i(far_val), .dut_lines_i(lines_out), .dut_oe_i(lines_oe),
        .dut_tb_i(tb_out), .dut_tb_oe_i(tb_oe), .lines_o(lines_in), .tb_line_o(tb_in));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [3:0] s, input logic [3:0] d, input logic p, input logic c);
        apb(1'b1, `REG_CONNECT, {22'h0, c, p, d, s});
        apb(1'b0, `REG_STATUS, 32'h0);
    endtask
    task automatic pulse_begin(input logic [1:0] m);
        begin_c <= m;
        cyc(1);
        begin_c <= 2'h0;
    endtask
    // sampled on the falling edge so register updates have landed
    task automatic watch(input int b, input int k);
        logic p;
        hi_cnt = 0;
        tg_cnt = 0;
        p = tb_out;
        repeat (k) begin
            @(negedge core_clk);
            hi_cnt += (lines_out[b] === 1'b1 && lines_oe[b] === 1'b1);
            tg_cnt += (tb_out !== p);
            p = tb_out;
        end
    endtask
    initial begin
        cyc(12);
        rst_b <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(q, `CTRL_RESET);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(q & 32'h1e7, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({e, q[30:0]}, 32'h8000_0000);
        $display("test reset done");
        cmd(SRC_LOCAL, 4'h0, 1'b0, 1'b1);
        chk({q[0], lines_oe}, 8'h80);
        cmd(SRC_LOCAL, DST_TB_LINE, 1'b0, 1'b1);
        chk({q[8], q[0], tb_oe}, 3'b101);
        cyc(4);
        watch(0, 32);
        chk(tg_cnt, 32);
        cmd(SRC_LOCAL, DST_TB_LINE, 1'b0, 1'b0);
        chk({q[8], tb_oe}, 2'b00);
        $display("test local export done");
        apb(1'b1, `REG_CTRL, 32'h1e);
        cmd(SRC_LOCAL, DST_TB_LINE, 1'b0, 1'b1);
        cyc(60);
        watch(0, 100);
        chk(tg_cnt, 100 / `USB_HALF_CYC);
        cmd(SRC_LOCAL, DST_TB_LINE, 1'b0, 1'b0);
        clk_run <= 1'b1;
        cmd(SRC_TB_LINE, DST_MASTER, 1'b0, 1'b1);
        chk(q[6:5], TB_LINE7);
        cyc(100);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(q[4:3], RATE_1M);
        clk_run <= 1'b0;
        cmd(SRC_TB_LINE, DST_MASTER, 1'b0, 1'b0);
        chk(q[6:5], TB_LOCAL);
        $display("test timebase import done");
        apb(1'b1, `REG_CTRL, 32'h12);
        cmd(SRC_STAR, DST_START, 1'b0, 1'b1);
        chk(q[0], 1'b1);
        apb(1'b1, `REG_CTRL, 32'h1a);
        cmd(SRC_STAR, DST_START, 1'b0, 1'b1);
        chk(q[0], 1'b0);
        cmd(SRC_STAR, DST_START, 1'b0, 1'b0);
        cmd(SRC_CLK10, DST_MASTER, 1'b0, 1'b1);
        chk(q[6:5], TB_CLK10);
        cmd(SRC_CLK10, DST_MASTER, 1'b0, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h19);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(q, 32'h19);
        $display("test timebase select done");
        cmd(4'h3, DST_START, 1'b0, 1'b1);
        far_val[3] <= 1'b1;
        cyc(8);
        far_val[3] <= 1'b0;
        cyc(4);
        far_val[3] <= 1'b1;
        cyc(8);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk({st_cnt[0][7:0], st_cnt[1][7:0], 14'h0, q[2:1]}, {8'd1, 8'd0, 14'h0, 2'b01});
        apb(1'b1, `REG_START_ARM, 32'h1);
        pulse_begin(2'b11);
        cyc(8);
        chk({st_cnt[0][15:0], st_cnt[1][15:0]}, {16'd1, 16'd1});
        apb(1'b1, `REG_START_ARM, 32'h2);
        cmd(SRC_START, 4'h5, 1'b1, 1'b1);
        apb(1'b0, `REG_LINE_MAP, 32'h0);
        chk(q[6:0], 7'h20);
        fork
            pulse_begin(2'b10);
            watch(5, 12);
        join
        chk(hi_cnt, 1);
        $display("test start trigger done");
        cmd(SRC_RX_EVENT, 4'h2, 1'b0, 1'b1);
        fork
            begin
                eof <= 2'b01;
                acc <= 2'b01;
                cyc(1);
                acc <= 2'b00;
                cyc(1);
                eof <= 2'b00;
            end
            watch(2, 12);
        join
        chk(hi_cnt, 1);
        cmd(SRC_FAULT, 4'h1, 1'b0, 1'b1);
        chk(q[0], 1'b1);
        cmd(SRC_FAULT, 4'h6, 1'b1, 1'b1);
        chk(q[0], 1'b1);
        cmd(SRC_FAULT, 4'h4, 1'b0, 1'b1);
        chk(q[0], 1'b0);
        watch(4, 4);
        chk(hi_cnt, 4);
        fault_n <= 2'b10;
        cyc(6);
        watch(4, 4);
        chk(hi_cnt, 0);
        $display("test frame events done");
        cmd(SRC_RESYNC, 4'h0, 1'b0, 1'b1);
        watch(0, 20 * HALF);
        chk(hi_cnt, 10 * HALF);
        cmd(4'h6, DST_RESYNC, 1'b0, 1'b1);
        chk(q[7], 1'b1);
        cmd(4'h6, DST_RESYNC, 1'b0, 1'b0);
        chk(q[7], 1'b0);
        hi_cnt = stamp;
        cyc(400);
        chk(stamp - hi_cnt, 32'd10);
        $display("test resync done");
        stop_test();
    end
    // whole run needs under 3000 cycles
    initial begin
        cyc(20000);
        n_fail++;
        stop_test();
    end
endmodule // sync_terminal_router_tb
